// ==== logic/ivrp_pkg.sv ====
// Shared constants for the virtual register port and its host controller.
package ivrp_pkg;
  localparam int        CLK_HZ      = 100_000_000;
  localparam int        SCL_STD_HZ  = 100_000;
  localparam int        SCL_FAST_HZ = 400_000;
  localparam logic [6:0] DEV_ADDR   = 7'h49;
  localparam logic [7:0] ADDR_WR    = 8'h92;
  localparam logic [7:0] ADDR_RD    = 8'h93;
  // Physical registers of the target.
  localparam logic [7:0] REG_STAT   = 8'h00;
  localparam logic [7:0] REG_WMB    = 8'h01;
  localparam logic [7:0] REG_RMB    = 8'h02;
  localparam int        BIT_FULL    = 1;
  localparam int        BIT_RDY     = 0;
  localparam int        BIT_WMARK   = 7;
  localparam int        FIFO_DEPTH  = 32;
  localparam int        FIFO_W      = 9;
  // Host controller registers on APB.
  localparam logic [7:0] H_CTRL     = 8'h00;
  localparam logic [7:0] H_STAT     = 8'h04;
  localparam logic [7:0] H_RDAT     = 8'h08;
  localparam int        HC_GO       = 0;
  localparam int        HC_RD       = 1;
  localparam int        HC_VADDR    = 8;
  localparam int        HC_WDATA    = 16;
  localparam int        HS_BUSY     = 0;
  localparam int        HS_DONE     = 1;
  localparam int        HS_NACK     = 2;
endpackage : ivrp_pkg

// ==== logic/ivrp_link_if.sv ====
// Two-wire link between the host controller and the target port.
`timescale 1ns/1ps
`default_nettype none
interface ivrp_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire  scl;
  wire  sda;
  // Open-drain wires: any enabled driver pulls low, otherwise pulled high.
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : ivrp_link_if
`default_nettype wire

// ==== logic/ivrp_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module ivrp_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Fill side
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  // Drain side
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
  } ivrp_fifo_st_t;
  ivrp_fifo_st_t q_ff, nxt_q;

  assign in_ready  = (q_ff.wp ^ q_ff.rp) != {1'b1, {AW{1'b0}}};
  assign out_valid = q_ff.wp != q_ff.rp;
  assign out_data  = q_ff.mem[q_ff.rp[AW-1:0]];

  always_comb begin
    nxt_q = q_ff;
    if (in_valid && in_ready) begin
      nxt_q.mem[q_ff.wp[AW-1:0]] = in_data;
      nxt_q.wp = q_ff.wp + (AW+1)'(1);
    end
    if (out_valid && out_ready) begin
      nxt_q.rp = q_ff.rp + (AW+1)'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule : ivrp_fifo
`default_nettype wire

// ==== logic/ivrp_dev.sv ====
// Two-wire target port with status, write mailbox and read mailbox.
// What this block does
// RULE_01 - Answer at address 49h: 92h write, 93h read
// RULE_02 - Work with 100 kHz and 400 kHz clocks
// RULE_03 - Status at 0x00: bit1 slot full, bit0 ready
// RULE_04 - Slot full 1 blocks host writes, 0 allows
// RULE_05 - Ready reads 1 while read byte waits
// RULE_06 - Write mailbox at 0x01 takes addresses and data
// RULE_07 - Read mailbox at 0x02 holds outgoing byte
// RULE_08 - Address bit 7 set marks write, clear read
// RULE_09 - Host polls, sends marked address, polls, data
// RULE_10 - Taking a write address clears slot full
// RULE_11 - Host reads mailbox only after ready is 1
// RULE_12 - Multi-byte values big-endian, high byte first
// RULE_13 - Host reads multi-byte values ascending address
// RULE_14 - Host writes multi-byte values ascending address
// RULE_15 - Four-byte floats are binary32, bias 127
// RULE_16 - Host write sets slot full until consumed
// RULE_17 - Host read of read mailbox clears ready
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ivrp_dev (
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Two-wire link
  ivrp_link_if.dev    lk,
  // Inbound bytes: in_is_data low means a virtual address byte
  output logic [7:0]  in_data,
  output logic        in_is_data,
  output logic        in_valid,
  input  wire logic   in_ready,
  // Outbound bytes for the read mailbox
  input  wire logic [7:0] out_data,
  input  wire logic   out_valid,
  output logic        out_ready,
  // Flag levels
  output logic        slot_full,
  output logic        byte_ready
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WREG = 3'b011,
    ST_WDAT = 3'b010,
    ST_ACK  = 3'b110,
    ST_RD   = 3'b111,
    ST_RACK = 3'b101
  } ivrp_dev_state_t;

  typedef struct packed {
    logic [1:0]      s1;
    logic [1:0]      s2;
    logic [1:0]      s3;
    logic [1:0]      flt;
    logic [1:0]      old;
    ivrp_dev_state_t st;
    ivrp_dev_state_t ret;
    logic [7:0]      sr;
    logic [3:0]      cnt;
    logic            mack;
    logic [7:0]      ptr;
    logic            sda_oe;
    logic [7:0]      wmb;
    logic            full;
    logic [7:0]      rmb;
    logic            rdy;
    logic            pend_wr;
  } ivrp_dev_st_t;

  ivrp_dev_st_t q_ff, nxt_q;

  logic       f_ready;
  logic [8:0] f_out;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       ack;
  logic [7:0] rdval;

  ivrp_fifo #(
    .W     (ivrp_pkg::FIFO_W),
    .DEPTH (ivrp_pkg::FIFO_DEPTH)
  ) ivrp_fifo_i (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_data   ({q_ff.pend_wr, q_ff.wmb}),
    .in_valid  (q_ff.full),
    .in_ready  (f_ready),
    .out_data  (f_out),
    .out_valid (in_valid),
    .out_ready (in_ready)
  );

  // Bytes pass in arrival order, so the big-endian layout and binary32
  // fields of multi-byte values reach the register space unchanged.
  assign in_data    = f_out[7:0]; // RULE_12 RULE_15
  assign in_is_data = f_out[8];
  assign out_ready  = !q_ff.rdy;
  assign slot_full  = q_ff.full;
  assign byte_ready = q_ff.rdy;
  assign lk.dev_sda_o  = 1'b0;
  assign lk.dev_sda_oe = q_ff.sda_oe;

  always_comb begin
    nxt_q = q_ff;
    rise  = q_ff.flt[1] && !q_ff.old[1];
    fall  = !q_ff.flt[1] && q_ff.old[1];
    start = q_ff.flt[1] && q_ff.old[1] && q_ff.old[0] && !q_ff.flt[0];
    stop  = q_ff.flt[1] && q_ff.old[1] && !q_ff.old[0] && q_ff.flt[0];
    ack   = 1'b1;
    rdval = 8'h00;
    case (q_ff.ptr)
      ivrp_pkg::REG_STAT: begin
        rdval[ivrp_pkg::BIT_FULL] = q_ff.full; // RULE_03 RULE_04
        rdval[ivrp_pkg::BIT_RDY]  = q_ff.rdy; // RULE_05
      end
      ivrp_pkg::REG_RMB: rdval = q_ff.rmb; // RULE_07
      default: rdval = 8'h00;
    endcase
    // A filtered line changes only once the second and third stages agree.
    nxt_q.s1  = {lk.scl, lk.sda};
    nxt_q.s2  = q_ff.s1;
    nxt_q.s3  = q_ff.s2;
    nxt_q.old = q_ff.flt;
    for (int i = 0; i < 2; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i]) begin
        nxt_q.flt[i] = q_ff.s3[i];
      end
    end
    // Hand the mailbox byte to the FIFO; a full FIFO keeps the slot busy.
    if (q_ff.full && f_ready) begin
      nxt_q.full    = 1'b0; // RULE_10 RULE_16
      nxt_q.pend_wr = q_ff.pend_wr ? 1'b0 : q_ff.wmb[ivrp_pkg::BIT_WMARK]; // RULE_08
    end
    // Events come from the filtered lines, so any bus rate slower than the filter works.
    if (stop) begin // RULE_02
      nxt_q.st     = ST_IDLE;
      nxt_q.sda_oe = 1'b0;
    end else if (start) begin
      nxt_q.st     = ST_ADDR;
      nxt_q.cnt    = 4'h0;
      nxt_q.sda_oe = 1'b0;
    end else if (rise) begin
      case (q_ff.st)
        ST_ADDR, ST_WREG, ST_WDAT: begin
          nxt_q.sr  = {q_ff.sr[6:0], q_ff.flt[0]};
          nxt_q.cnt = q_ff.cnt + 4'h1;
        end
        ST_RACK: begin
          nxt_q.mack = !q_ff.flt[0];
          if (q_ff.ptr == ivrp_pkg::REG_RMB) begin
            nxt_q.rdy = 1'b0; // RULE_17
          end
        end
        default: ;
      endcase
    end else if (fall) begin
      case (q_ff.st)
        ST_ADDR, ST_WREG, ST_WDAT: begin
          if (q_ff.cnt == 4'h8) begin
            nxt_q.ret = ST_WDAT;
            if (q_ff.st == ST_ADDR) begin
              ack       = q_ff.sr[7:1] == ivrp_pkg::DEV_ADDR; // RULE_01
              nxt_q.ret = q_ff.sr[0] ? ST_RD : ST_WREG;
            end else if (q_ff.st == ST_WREG) begin
              nxt_q.ptr = q_ff.sr;
            end else if (q_ff.ptr == ivrp_pkg::REG_WMB && !q_ff.full) begin
              // A byte sent while the slot is full is dropped.
              nxt_q.wmb  = q_ff.sr; // RULE_06
              nxt_q.full = 1'b1; // RULE_16
            end
            nxt_q.st     = ack ? ST_ACK : ST_IDLE;
            nxt_q.sda_oe = ack;
          end
        end
        ST_ACK: begin
          nxt_q.st     = q_ff.ret;
          nxt_q.cnt    = 4'h0;
          nxt_q.sda_oe = 1'b0;
          if (q_ff.ret == ST_RD) begin
            nxt_q.sr     = rdval;
            nxt_q.sda_oe = !rdval[7];
            nxt_q.cnt    = 4'h1;
          end
        end
        ST_RD: begin
          if (q_ff.cnt == 4'h8) begin
            nxt_q.sda_oe = 1'b0;
            nxt_q.st     = ST_RACK;
          end else begin
            nxt_q.sr     = {q_ff.sr[6:0], 1'b0};
            nxt_q.sda_oe = !q_ff.sr[6];
            nxt_q.cnt    = q_ff.cnt + 4'h1;
          end
        end
        ST_RACK: begin
          nxt_q.st = ST_IDLE;
          if (q_ff.mack) begin
            nxt_q.st     = ST_RD;
            nxt_q.sr     = rdval;
            nxt_q.sda_oe = !rdval[7];
            nxt_q.cnt    = 4'h1;
          end
        end
        default: nxt_q.st = ST_IDLE;
      endcase
    end
    // Loading after the bus logic lets a new byte win over a clear.
    if (out_valid && !q_ff.rdy) begin
      nxt_q.rmb = out_data;
      nxt_q.rdy = 1'b1; // RULE_05
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff     <= '0;
      q_ff.s1  <= 2'h3;
      q_ff.s2  <= 2'h3;
      q_ff.s3  <= 2'h3;
      q_ff.flt <= 2'h3;
      q_ff.old <= 2'h3;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule : ivrp_dev
`default_nettype wire

// ==== logic/ivrp_host.sv ====
// Host controller running virtual register accesses from APB orders.
`timescale 1ns/1ps
`default_nettype none
module ivrp_host #(
  parameter int SCL_HZ = ivrp_pkg::SCL_STD_HZ,
  parameter int QTR    = ivrp_pkg::CLK_HZ / (4 * SCL_HZ)
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-wire link
  ivrp_link_if.host        lk
);
  typedef enum logic [1:0] {
    K_S = 2'b00,
    K_W = 2'b01,
    K_R = 2'b11,
    K_P = 2'b10
  } ivrp_kind_t;

  typedef struct packed {
    logic [2:0]  sy;
    logic        flt;
    logic        busy;
    logic        done;
    logic        nack;
    logic        is_rd;
    logic [7:0]  vaddr;
    logic [7:0]  wdata;
    logic [7:0]  rdat;
    logic [1:0]  ph;
    logic [2:0]  op;
    logic [3:0]  bitn;
    logic [1:0]  qtr;
    logic [15:0] tick;
    logic [7:0]  rx;
    logic        scl_oe;
    logic        sda_oe;
  } ivrp_host_st_t;

  ivrp_host_st_t q_ff, nxt_q;

  logic       sel;
  logic       t_rd;
  logic [7:0] t_reg;
  logic [7:0] t_val;
  ivrp_kind_t kind;
  logic [7:0] obyte;
  logic       last;
  logic       ok;

  assign sel     = psel && penable;
  assign pready  = 1'b1;
  assign pslverr = !(paddr == ivrp_pkg::H_CTRL || paddr == ivrp_pkg::H_STAT
                     || paddr == ivrp_pkg::H_RDAT);
  assign lk.host_scl_o  = 1'b0;
  assign lk.host_sda_o  = 1'b0;
  assign lk.host_scl_oe = q_ff.scl_oe;
  assign lk.host_sda_oe = q_ff.sda_oe;

  always_comb begin
    prdata = 32'h0;
    case (paddr)
      ivrp_pkg::H_CTRL: prdata = {8'h0, q_ff.wdata, q_ff.vaddr, 6'h0, q_ff.is_rd, 1'b0};
      ivrp_pkg::H_STAT: prdata = {29'h0, q_ff.nack, q_ff.done, q_ff.busy};
      ivrp_pkg::H_RDAT: prdata = {24'h0, q_ff.rdat};
      default: prdata = 32'h0;
    endcase
  end

  always_comb begin
    nxt_q = q_ff;
    // Phases: poll, send address, poll, move the data byte.
    t_rd  = q_ff.ph != 2'd1 && !(q_ff.ph == 2'd3 && !q_ff.is_rd);
    t_reg = ivrp_pkg::REG_STAT;
    t_val = q_ff.wdata;
    if (q_ff.ph == 2'd1) begin
      t_reg = ivrp_pkg::REG_WMB;
      t_val = q_ff.vaddr;
      t_val[ivrp_pkg::BIT_WMARK] = !q_ff.is_rd; // RULE_08
    end else if (q_ff.ph == 2'd3) begin
      t_reg = q_ff.is_rd ? ivrp_pkg::REG_RMB : ivrp_pkg::REG_WMB;
    end
    kind  = K_W;
    obyte = ivrp_pkg::ADDR_WR;
    case ({t_rd, q_ff.op})
      4'h0, 4'h8, 4'hc: kind = K_S;
      4'h4, 4'hb, 4'hf: kind = K_P;
      4'h2, 4'ha:       obyte = t_reg;
      4'h3:             obyte = t_val;
      4'hd:             obyte = ivrp_pkg::ADDR_RD;
      4'he:             kind = K_R;
      default:          obyte = ivrp_pkg::ADDR_WR;
    endcase
    last = q_ff.op == (t_rd ? 3'd7 : 3'd4);
    ok   = q_ff.ph == 2'd2 && q_ff.is_rd ? q_ff.rx[ivrp_pkg::BIT_RDY]
                                         : !q_ff.rx[ivrp_pkg::BIT_FULL];
    nxt_q.sy  = {q_ff.sy[1:0], lk.sda};
    if (q_ff.sy[1] == q_ff.sy[2]) begin
      nxt_q.flt = q_ff.sy[2];
    end
    if (sel && pwrite && paddr == ivrp_pkg::H_CTRL && pwdata[ivrp_pkg::HC_GO]
        && !q_ff.busy) begin
      nxt_q.busy  = 1'b1;
      nxt_q.done  = 1'b0;
      nxt_q.nack  = 1'b0;
      nxt_q.is_rd = pwdata[ivrp_pkg::HC_RD];
      nxt_q.vaddr = pwdata[ivrp_pkg::HC_VADDR +: 8];
      nxt_q.wdata = pwdata[ivrp_pkg::HC_WDATA +: 8];
      nxt_q.ph    = 2'd0;
      nxt_q.op    = 3'd0;
      nxt_q.bitn  = 4'd0;
      nxt_q.qtr   = 2'd0;
      nxt_q.tick  = 16'h0;
    end else if (q_ff.busy) begin
      nxt_q.tick = q_ff.tick + 16'h1;
      if (q_ff.tick == 16'(QTR - 1)) begin
        nxt_q.tick = 16'h0;
        nxt_q.qtr  = q_ff.qtr + 2'd1;
        if (q_ff.qtr == 2'd2 && kind == K_R && q_ff.bitn < 4'd8) begin
          nxt_q.rx = {q_ff.rx[6:0], q_ff.flt};
        end
        if (q_ff.qtr == 2'd2 && kind == K_W && q_ff.bitn == 4'd8) begin
          nxt_q.nack = q_ff.nack | q_ff.flt;
        end
        if (q_ff.qtr == 2'd3) begin
          nxt_q.bitn = q_ff.bitn + 4'd1;
          if (kind == K_S || kind == K_P || q_ff.bitn == 4'd8) begin
            nxt_q.bitn = 4'd0;
            nxt_q.op   = q_ff.op + 3'd1;
            if (last) begin
              nxt_q.op = 3'd0;
              case (q_ff.ph)
                2'd0:    nxt_q.ph = ok ? 2'd1 : 2'd0; // RULE_09 RULE_11
                2'd1:    nxt_q.ph = 2'd2;
                2'd2:    nxt_q.ph = ok ? 2'd3 : 2'd2; // RULE_04 RULE_09 RULE_11
                default: begin
                  nxt_q.busy = 1'b0;
                  nxt_q.done = 1'b1;
                  if (q_ff.is_rd) begin
                    nxt_q.rdat = q_ff.rx;
                  end
                end
              endcase
            end
          end
        end
      end
    end
    // Drive levels for the coming quarter; data bits move while clock low, start and stop move data while clock high.
    nxt_q.scl_oe = 1'b0;
    nxt_q.sda_oe = 1'b0;
    if (nxt_q.busy) begin
      case (kind)
        K_S: begin
          nxt_q.scl_oe = nxt_q.qtr == 2'd3;
          nxt_q.sda_oe = nxt_q.qtr[1];
        end
        K_P: begin
          nxt_q.scl_oe = !nxt_q.qtr[1];
          nxt_q.sda_oe = nxt_q.qtr == 2'd0 ? q_ff.sda_oe : nxt_q.qtr != 2'd3;
        end
        default: begin
          nxt_q.scl_oe = !nxt_q.qtr[1];
          nxt_q.sda_oe = kind == K_W && nxt_q.bitn < 4'd8
                         && !obyte[3'd7 - nxt_q.bitn[2:0]];
          if (nxt_q.qtr == 2'd0) begin
            nxt_q.sda_oe = q_ff.sda_oe;
          end
        end
      endcase
      if (nxt_q.op != q_ff.op || nxt_q.ph != q_ff.ph || !q_ff.busy) begin
        nxt_q.scl_oe = q_ff.scl_oe;
        nxt_q.sda_oe = q_ff.sda_oe;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_ff     <= '0;
      q_ff.sy  <= 3'h7;
      q_ff.flt <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule : ivrp_host
`default_nettype wire

// ==== tb/ivrp_link_sva.sv ====
// Protocol checker for the two-wire link between host controller and target port.
`timescale 1ns/1ps
`default_nettype none
module ivrp_link_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link drivers and resolved wires
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts clock pulses during which the target keeps pulling data low.
  logic [3:0] hold_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_ff <= 4'h0;
    else if (!dev_sda_oe) hold_ff <= 4'h0;
    else if (scl && !$past(scl) && hold_ff != 4'hf) hold_ff <= hold_ff + 4'h1;
  end
  a_drv_open_drain: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("link data driven high");
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  a_dev_sda_edge: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("target changed data while clock high");
  a_dev_answer_lag: assert property ($rose(dev_sda_oe) |-> !$past(scl, 3))
    else $error("target answered too soon after clock fall");
  a_one_sda_driver: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
    else $error("both ends drive data while clock high");
  a_start_by_host: assert property ($fell(sda) && scl && $past(scl) |-> host_sda_oe)
    else $error("start condition not made by host");
  a_stop_by_host: assert property ($rose(sda) && scl && $past(scl)
    |-> $past(host_sda_oe))
    else $error("stop condition not made by host");
  a_dev_hold_max: assert property (hold_ff <= 4'h9)
    else $error("target held data longer than one byte and acknowledge");
  c_start: cover property ($fell(sda) && scl);
  c_dev_ack: cover property ($rose(dev_sda_oe));
  c_stop: cover property ($rose(sda) && scl);
endmodule : ivrp_link_sva
`default_nettype wire

// ==== tb/test_i2c_virtual_register_port.sv ====
// Testbench joining the host controller and the target port over the link.
`timescale 1ns/1ps
`default_nettype none
module test_i2c_virtual_register_port;
  localparam int LIM = 20000;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  in_data;
  logic        in_is_data;
  logic        in_valid;
  logic        in_ready;
  logic [7:0]  out_data;
  logic        out_valid;
  logic        out_ready;
  logic        slot_full;
  logic        byte_ready;
  logic        chk_en;
  logic        drain;
  logic        err;
  logic [31:0] rd;
  logic [7:0]  va;
  logic [7:0]  wd;
  logic [8:0]  exp_in[$];
  logic [31:0] exp_rd[$];
  int          mismatches;
  int          tests_run;
  int          n;
  ivrp_link_if ivrp_link_if_i ();
  ivrp_host #(.QTR(8)) ivrp_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lk(ivrp_link_if_i.host));
  ivrp_dev ivrp_dev_i (
    .pclk(pclk), .presetn(presetn), .lk(ivrp_link_if_i.dev), .in_data(in_data),
    .in_is_data(in_is_data), .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .slot_full(slot_full),
    .byte_ready(byte_ready));
  ivrp_link_sva ivrp_link_sva_i (
    .pclk(pclk), .presetn(presetn), .host_scl_o(ivrp_link_if_i.host_scl_o),
    .host_scl_oe(ivrp_link_if_i.host_scl_oe), .host_sda_o(ivrp_link_if_i.host_sda_o),
    .host_sda_oe(ivrp_link_if_i.host_sda_oe), .dev_sda_o(ivrp_link_if_i.dev_sda_o),
    .dev_sda_oe(ivrp_link_if_i.dev_sda_oe), .scl(ivrp_link_if_i.scl),
    .sda(ivrp_link_if_i.sda));
  task automatic results();
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic bound(input int cnt);
    if (cnt >= LIM) begin
      check(cnt, 32'h0);
      results();
    end
  endtask : bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk_en <= c;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < LIM);
    bound(n);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk_en <= 1'b0;
  endtask : apb
  task automatic wait_idle();
    int k;
    k = 0;
    rd = 32'h1;
    while (rd[ivrp_pkg::HS_BUSY] !== 1'b0 && k < LIM) begin
      apb(1'b0, ivrp_pkg::H_STAT, 32'h0, 1'b0);
      k++;
    end
    bound(k);
  endtask : wait_idle
  task automatic vacc(input logic r, input logic [7:0] a, input logic [7:0] d, input logic w);
    if (r) exp_in.push_back({1'b0, a & 8'h7f});
    else begin
      exp_in.push_back({1'b0, a | 8'h80});
      exp_in.push_back({1'b1, d});
    end
    apb(1'b1, ivrp_pkg::H_CTRL, {8'h00, d, a, 6'h00, r, 1'b1}, 1'b0);
    if (w) begin
      wait_idle();
      exp_rd.push_back(32'h2);
      apb(1'b0, ivrp_pkg::H_STAT, 32'h0, 1'b1);
    end
  endtask : vacc
  task automatic vread(input logic [7:0] a, input logic [7:0] d);
    vacc(1'b1, a, 8'h00, 1'b0);
    // The answer comes during the host's ready poll, before the status byte is read, so the first poll finds ready set.
    repeat (2500) @(posedge pclk);
    out_data <= d;
    out_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (out_ready !== 1'b1 && n < LIM);
    bound(n);
    out_valid <= 1'b0;
    out_data <= ~d;
    @(posedge pclk);
    check({31'h0, byte_ready}, 32'h1);
    wait_idle();
    exp_rd.push_back({24'h0, d});
    apb(1'b0, ivrp_pkg::H_RDAT, 32'h0, 1'b1);
    check({31'h0, byte_ready}, 32'h0);
  endtask : vread
  always @(posedge pclk) in_ready <= drain ? 1'($urandom) : 1'b0;
  always @(posedge pclk) begin
    if (presetn && in_valid && in_ready) begin
      check({in_is_data, in_data}, exp_in.pop_front());
    end
    if (psel && penable && pready && !pwrite && chk_en) begin
      check(prdata, exp_rd.pop_front());
    end
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, chk_en, drain, out_valid} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    out_data = 8'h00;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(32'h564ac83b));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    exp_rd.push_back(32'h0);
    apb(1'b0, ivrp_pkg::H_STAT, 32'h0, 1'b1);
    check({30'h0, slot_full, byte_ready}, 32'h0);
    exp_rd.push_back(32'h0);
    apb(1'b0, 8'h0c, 32'h0, 1'b1);
    check({31'h0, err}, 32'h1);
    // Sixteen writes fill the inbound buffer while the user side stalls.
    for (int i = 0; i < 12; i++) begin
      va = 8'($urandom);
      wd = 8'($urandom);
      vacc(1'b0, va, wd, 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      vacc(1'b0, 8'h20 + 8'(k), 8'(32'h3e200000 >> (24 - 8 * k)), 1'b1);
    end
    vacc(1'b0, 8'h55, 8'haa, 1'b0);
    // The order register reads back with the read flag in its own bit.
    exp_rd.push_back(32'h00aa5500);
    apb(1'b0, ivrp_pkg::H_CTRL, 32'h0, 1'b1);
    repeat (3000) @(posedge pclk);
    check({31'h0, slot_full}, 32'h1);
    drain <= 1'b1;
    wait_idle();
    n = 0;
    while (exp_in.size() != 0 && n < LIM) begin
      @(posedge pclk);
      n++;
    end
    bound(n);
    for (int i = 0; i < 2; i++) vread(8'h20 + 8'(i), 8'($urandom));
    repeat (20) @(posedge pclk);
    check(exp_in.size() + exp_rd.size(), 32'h0);
    results();
  end
endmodule : test_i2c_virtual_register_port
`default_nettype wire
